// >>> rtl/timer3_split_autoreload.sv
/*
 * Split-capable auto-reload timer with its register port.
 * Assumes a register port with single-cycle read and write strobes on clk_sys
 * and a timer interrupt enable kept by the interrupt controller outside.
 */
`timescale 1ns/1ps
module timer3_split_autoreload (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // register port
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWrite,
    input  wire logic       sfrRead,
    input  wire logic [7:0] sfrWdata,
    output logic      [7:0] sfrRdata,
    // external oscillator
    input  wire logic       extOsc,
    // interrupt
    input  wire logic       timerIntEnable,
    output logic            timerIrq
);
    typedef struct packed {
        logic [7:0] reloadLow;
        logic [7:0] reloadHigh;
        logic [7:0] countLow;
        logic [7:0] countHigh;
        logic       highFlag;
        logic       lowFlag;
        logic       lowIntEn;
        logic       split;
        logic       run;
        logic       extSel;
        logic       highSysSel;
        logic       lowSysSel;
        logic [7:0] readData;
        logic       irq;
    } timer_s;

    timer_s             st;
    timer_s             next_st;
    logic               tickDiv12;
    logic               tickExt;
    logic               tickHigh;
    logic               tickLow;
    logic               incHigh;
    logic               incLow;
    logic               highWrap;
    logic               lowWrap;
    logic [15:0]        wideCount;
    logic [15:0]        wideNext;
    logic               writeCtl;
    timer3_pkg::mode_e  mode;

    prescale_div12 u_div12 (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .tickDiv12 (tickDiv12)
    );

    ext_clock_tick u_ext (
        .clk_sys (clk_sys),
        .reset   (reset),
        .extOsc  (extOsc),
        .tickExt (tickExt)
    );

    always_comb begin
        next_st = st;
        mode = st.split ? timer3_pkg::MODE_SPLIT : timer3_pkg::MODE_WIDE; // R1
        // one alternate source for both bytes
        tickHigh = timer3_pkg::pickTick(st.highSysSel, st.extSel,
                                        tickDiv12, tickExt); // R5 R6 R7 R8
        tickLow = timer3_pkg::pickTick(st.lowSysSel, st.extSel,
                                       tickDiv12, tickExt); // R5 R6 R7 R8
        incHigh = 1'b0;
        incLow = 1'b0;
        highWrap = 1'b0;
        lowWrap = 1'b0;
        wideCount = {st.countHigh, st.countLow};
        wideNext = wideCount;
        writeCtl = sfrWrite && (sfrAddr == timer3_pkg::ADDR_CONTROL);

        case (mode)
            timer3_pkg::MODE_WIDE: begin
                // low-byte select clocks the whole word
                incLow = st.run & tickLow; // R2 R16
                if (incLow) begin
                    lowWrap = (st.countLow == timer3_pkg::BYTE_ALL_ONES);
                    highWrap = (wideCount == timer3_pkg::WORD_ALL_ONES);
                    if (highWrap) begin
                        wideNext = {st.reloadHigh, st.reloadLow}; // R12
                    end else begin
                        wideNext = wideCount + 16'h0001;
                    end
                end
                next_st.countHigh = wideNext[15:8];
                next_st.countLow = wideNext[7:0]; // R11
            end
            timer3_pkg::MODE_SPLIT: begin
                incHigh = st.run & tickHigh; // R3 R16
                incLow = tickLow; // R3 R16
                if (incHigh) begin
                    highWrap = (st.countHigh == timer3_pkg::BYTE_ALL_ONES);
                    next_st.countHigh = highWrap ? st.reloadHigh
                                                 : st.countHigh + 8'h01; // R13
                end
                if (incLow) begin
                    lowWrap = (st.countLow == timer3_pkg::BYTE_ALL_ONES);
                    next_st.countLow = lowWrap ? st.reloadLow
                                               : st.countLow + 8'h01; // R13 R11
                end
            end
            default: begin
                next_st.countHigh = st.countHigh;
            end
        endcase

        // register writes land after counting so they win
        if (sfrWrite) begin
            case (sfrAddr)
                timer3_pkg::ADDR_RELOAD_LOW:  next_st.reloadLow = sfrWdata; // R9 R17
                timer3_pkg::ADDR_RELOAD_HIGH: next_st.reloadHigh = sfrWdata; // R10 R17
                timer3_pkg::ADDR_COUNT_LOW:   next_st.countLow = sfrWdata; // R11 R17
                timer3_pkg::ADDR_COUNT_HIGH:  next_st.countHigh = sfrWdata; // R17
                timer3_pkg::ADDR_CONTROL: begin
                    // bits 1 and 4 are not stored
                    next_st.highFlag = sfrWdata[timer3_pkg::CTL_HIGH_FLAG];
                    next_st.lowFlag = sfrWdata[timer3_pkg::CTL_LOW_FLAG];
                    next_st.lowIntEn = sfrWdata[timer3_pkg::CTL_LOW_INT_EN];
                    next_st.split = sfrWdata[timer3_pkg::CTL_SPLIT];
                    next_st.run = sfrWdata[timer3_pkg::CTL_RUN];
                    next_st.extSel = sfrWdata[timer3_pkg::CTL_EXT_SEL]; // R4
                end
                timer3_pkg::ADDR_CLOCK_CONTROL: begin
                    next_st.highSysSel = sfrWdata[timer3_pkg::CKC_HIGH_SEL]; // R8
                    next_st.lowSysSel = sfrWdata[timer3_pkg::CKC_LOW_SEL]; // R8
                end
                default: begin
                    next_st.readData = st.readData;
                end
            endcase
        end

        // hardware set beats a clearing write
        if (highWrap) begin
            next_st.highFlag = 1'b1; // R12 R13 R15
        end
        if (lowWrap) begin
            next_st.lowFlag = 1'b1; // R13 R15
        end

        if (sfrRead) begin
            case (sfrAddr)
                timer3_pkg::ADDR_CONTROL: begin
                    next_st.readData = {st.highFlag, st.lowFlag, st.lowIntEn, 1'b0,
                                        st.split, st.run, 1'b0, st.extSel}; // R4
                end
                timer3_pkg::ADDR_RELOAD_LOW:  next_st.readData = st.reloadLow; // R9
                timer3_pkg::ADDR_RELOAD_HIGH: next_st.readData = st.reloadHigh; // R10
                timer3_pkg::ADDR_COUNT_LOW:   next_st.readData = st.countLow; // R11
                timer3_pkg::ADDR_COUNT_HIGH:  next_st.readData = st.countHigh;
                timer3_pkg::ADDR_CLOCK_CONTROL: begin
                    next_st.readData = {2'b00, st.highSysSel, st.lowSysSel, 4'h0};
                end
                default: next_st.readData = timer3_pkg::RESET_BYTE;
            endcase
        end

        next_st.irq = timerIntEnable &
                      (next_st.highFlag | (next_st.lowIntEn & next_st.lowFlag)); // R14
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sfrRdata = st.readData;
    assign timerIrq = st.irq;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    sequence s_wideAtTop;
        !st.split && st.run && st.lowSysSel && !sfrWrite &&
        ({st.countHigh, st.countLow} == timer3_pkg::WORD_ALL_ONES);
    endsequence

    sequence s_highAtTop;
        st.split && st.run && st.highSysSel && !sfrWrite &&
        (st.countHigh == timer3_pkg::BYTE_ALL_ONES);
    endsequence

    sequence s_lowAtTop;
        st.split && st.lowSysSel && !sfrWrite &&
        (st.countLow == timer3_pkg::BYTE_ALL_ONES);
    endsequence

    a_wide_reload_flag: assert property ( // R12
        s_wideAtTop |=> ({st.countHigh, st.countLow} ==
                         {$past(st.reloadHigh), $past(st.reloadLow)}) && st.highFlag)
        else $error("wide wrap did not reload or flag");

    a_split_high_reload: assert property ( // R13
        s_highAtTop |=> (st.countHigh == $past(st.reloadHigh)) && st.highFlag)
        else $error("high byte wrap did not reload or flag");

    a_wide_hold_stop: assert property ( // R2
        (!st.split && !st.run && !sfrWrite) |=>
            ({st.countHigh, st.countLow} == $past({st.countHigh, st.countLow})))
        else $error("stopped wide counter moved");

    a_low_free_run: assert property ( // R3
        (st.split && !st.run && st.lowSysSel && !sfrWrite && st.countLow != 8'hFF)
            |=> (st.countLow == $past(st.countLow) + 8'h01))
        else $error("split low byte did not count");

    a_unused_bits_zero: assert property ( // R4
        (sfrRead && sfrAddr == timer3_pkg::ADDR_CONTROL) |=>
            (sfrRdata[1] == 1'b0) && (sfrRdata[4] == 1'b0))
        else $error("unused control bits read nonzero");

    a_flag_sticky: assert property ( // R15
        (st.highFlag && !writeCtl) |=> st.highFlag)
        else $error("high flag cleared without a write");

    a_prescale_period: assert property ( // R5
        tickDiv12 |=> !tickDiv12 [*8] ##1 !tickDiv12 [*3] ##1 tickDiv12)
        else $error("prescaler period is not twelve");

    a_ext_tick_pulse: assert property ( // R16
        tickExt |=> !tickExt [*2])
        else $error("external tick not a single pulse");

    a_count_write_wins: assert property ( // R17
        (sfrWrite && sfrAddr == timer3_pkg::ADDR_COUNT_LOW) |=>
            (st.countLow == $past(sfrWdata)))
        else $error("count write lost to increment");

    a_irq_from_flag: assert property ( // R14
        (timerIntEnable && st.highFlag && !writeCtl) |=> timerIrq)
        else $error("high flag did not raise interrupt");

    a_split_low_reload: assert property ( // R13
        s_lowAtTop |=> (st.countLow == $past(st.reloadLow)) && st.lowFlag)
        else $error("low byte wrap did not reload or flag");

    a_wide_low_flag: assert property ( // R13
        s_wideAtTop |=> st.lowFlag)
        else $error("wide wrap did not set low flag");

    a_high_gated_stop: assert property ( // R3
        (st.split && !st.run && !sfrWrite) |=> (st.countHigh == $past(st.countHigh)))
        else $error("stopped high byte moved");

    a_high_system_clock_count: assert property ( // R8
        (st.split && st.run && st.highSysSel && !sfrWrite && st.countHigh != 8'hFF)
            |=> (st.countHigh == $past(st.countHigh) + 8'h01))
        else $error("high byte on system clock did not count");

    a_shared_ext_select: assert property ( // R7
        (st.split && st.run && !st.highSysSel && !st.lowSysSel) |-> (incHigh == incLow))
        else $error("byte counters saw different alternate ticks");

    a_wide_run_tick: assert property ( // R16
        (!st.split && st.run && !st.lowSysSel && !tickLow && !sfrWrite) |=>
            ({st.countHigh, st.countLow} == $past({st.countHigh, st.countLow})))
        else $error("wide counter moved without a tick");

    a_low_flag_sticky: assert property ( // R15
        (st.lowFlag && !writeCtl) |=> st.lowFlag)
        else $error("low flag cleared without a write");

    a_reload_low_write: assert property ( // R9
        (sfrWrite && sfrAddr == timer3_pkg::ADDR_RELOAD_LOW) |=>
            (st.reloadLow == $past(sfrWdata)))
        else $error("reload low write lost");

    a_reload_high_write: assert property ( // R10
        (sfrWrite && sfrAddr == timer3_pkg::ADDR_RELOAD_HIGH) |=>
            (st.reloadHigh == $past(sfrWdata)))
        else $error("reload high write lost");

    a_count_high_write: assert property ( // R17
        (sfrWrite && sfrAddr == timer3_pkg::ADDR_COUNT_HIGH) |=>
            (st.countHigh == $past(sfrWdata)))
        else $error("count high write lost to increment");

    a_read_count_low: assert property ( // R11
        (sfrRead && sfrAddr == timer3_pkg::ADDR_COUNT_LOW) |=>
            (sfrRdata == $past(st.countLow)))
        else $error("count low read returned wrong byte");

    a_split_write_mode: assert property ( // R1
        writeCtl |=> (st.split == $past(sfrWdata[timer3_pkg::CTL_SPLIT])))
        else $error("control write did not set split mode");

    a_irq_low_flag: assert property ( // R14
        (timerIntEnable && st.lowIntEn && st.lowFlag && !writeCtl) |=> timerIrq)
        else $error("low flag did not raise interrupt");

    a_irq_quiet: assert property ( // R14
        !timerIntEnable |=> !timerIrq)
        else $error("interrupt raised while disabled");

endmodule : timer3_split_autoreload

// >>> common/timer3_pkg.sv
/*
 * Constants, types and the tick-select function of the split auto-reload timer.
 * Assumes one system clock at 125 MHz and the special-function-register port.
 */
// Contract
// R1: split mode enable 0 runs one 16-bit auto-reload counter, 1 runs two 8-bit ones.
// R2: in 16-bit mode the count advances only while run control is 1.
// R3: in split mode run control gates only the high byte; the low byte always counts.
// R4: control bit 1 reads as zero and ignores writes.
// R5: external clock select 0 picks the system clock divided by 12 as the alternate source.
// R6: external clock select 1 picks the external oscillator divided by 8, resynchronized.
// R7: in split mode one external clock select bit serves both byte counters.
// R8: per-byte clock select bits choose between system clock and the alternate source.
// R9: the reload low register is an 8-bit read/write register.
// R10: the reload high register is an 8-bit read/write register.
// R11: count low holds the counter low byte, or the low byte timer in split mode.
// R12: a 16-bit wrap from all ones loads the reload value and sets the high flag.
// R13: in split mode each byte reloads from its own register on wrap and sets its flag.
// R14: with the timer interrupt enabled, high overflow requests one; low too if enabled.
// R15: overflow flags are cleared only by software writing zero.
// R16: every selected tick becomes a one-cycle count enable in the system clock domain.
// R17: a register write takes effect next cycle and wins over a count in that cycle.
package timer3_pkg;

    // register addresses
    localparam logic [7:0] ADDR_CONTROL       = 8'h91;
    localparam logic [7:0] ADDR_RELOAD_LOW    = 8'h92;
    localparam logic [7:0] ADDR_RELOAD_HIGH   = 8'h93;
    localparam logic [7:0] ADDR_COUNT_LOW     = 8'h94;
    localparam logic [7:0] ADDR_COUNT_HIGH    = 8'h95;
    localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h9E;

    // control register fields
    localparam int unsigned CTL_HIGH_FLAG  = 7;
    localparam int unsigned CTL_LOW_FLAG   = 6;
    localparam int unsigned CTL_LOW_INT_EN = 5;
    localparam int unsigned CTL_SPLIT      = 3;
    localparam int unsigned CTL_RUN        = 2;
    localparam int unsigned CTL_EXT_SEL    = 0;

    // clock control register fields
    localparam int unsigned CKC_HIGH_SEL = 5;
    localparam int unsigned CKC_LOW_SEL  = 4;

    // reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // counter limits
    localparam logic [7:0]  BYTE_ALL_ONES = 8'hFF;
    localparam logic [15:0] WORD_ALL_ONES = 16'hFFFF;

    // prescaler and external divider
    localparam logic [3:0] PRESCALE_LAST = 4'hB;
    localparam logic [2:0] EXT_DIV_LAST  = 3'h7;

    typedef enum logic [1:0] {
        MODE_WIDE  = 2'b01,
        MODE_SPLIT = 2'b10
    } mode_e;

    // system clock, else alternate source chosen by external select
    function automatic logic pickTick(input logic sysSel, input logic extSel,
                                      input logic tickDiv12, input logic tickExt);
        return sysSel ? 1'b1 : (extSel ? tickExt : tickDiv12);
    endfunction : pickTick

endpackage : timer3_pkg

// >>> rtl/prescale_div12.sv
/*
 * System clock divided by 12: one-cycle tick every twelfth clock.
 * Assumes the system clock and its asynchronous reset.
 */
`timescale 1ns/1ps
module prescale_div12 (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // tick
    output logic      tickDiv12
);
    typedef struct packed {
        logic [3:0] count;
        logic       tick;
    } div_s;

    div_s st;
    div_s next_st;

    always_comb begin
        next_st = st;
        next_st.tick = (st.count == timer3_pkg::PRESCALE_LAST); // R5 R16
        if (st.count == timer3_pkg::PRESCALE_LAST) begin
            next_st.count = 4'h0;
        end else begin
            next_st.count = st.count + 4'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tickDiv12 = st.tick;
endmodule : prescale_div12

// >>> rtl/ext_clock_tick.sv
/*
 * External oscillator resynchronized, edge detected and divided by 8.
 * Assumes the oscillator is much slower than half the system clock.
 */
`timescale 1ns/1ps
module ext_clock_tick (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // oscillator pin
    input  wire logic extOsc,
    // tick
    output logic      tickExt
);
    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic       prev;
        logic [2:0] count;
        logic       tick;
    } ext_s;

    ext_s st;
    ext_s next_st;
    logic riseSeen;

    always_comb begin
        next_st = st;
        next_st.sync1 = extOsc; // R6
        next_st.sync2 = st.sync1;
        next_st.prev = st.sync2;
        riseSeen = st.sync2 & ~st.prev;
        next_st.tick = riseSeen && (st.count == timer3_pkg::EXT_DIV_LAST); // R6 R16
        if (riseSeen) begin
            next_st.count = st.count + 3'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tickExt = st.tick;
endmodule : ext_clock_tick

// >>> bench/timer3_split_autoreload_tb.sv
/*
 * Self-checking bench for the split auto-reload timer, driven through its register port.
 * Assumes the design files and the timer3_pkg package are compiled first.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin n_mismatch++; \
    $display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module timer3_split_autoreload_tb;
    logic       clk_sys;
    logic       reset;
    logic [7:0] sfrAddr;
    logic       sfrWrite;
    logic       sfrRead;
    logic [7:0] sfrWdata;
    logic [7:0] sfrRdata;
    logic       extOsc;
    logic       timerIntEnable;
    logic       timerIrq;
    int         n_mismatch;
    int         checked;
    logic [7:0] rv;

    timer3_split_autoreload u_dut (
        .clk_sys        (clk_sys),
        .reset          (reset),
        .sfrAddr        (sfrAddr),
        .sfrWrite       (sfrWrite),
        .sfrRead        (sfrRead),
        .sfrWdata       (sfrWdata),
        .sfrRdata       (sfrRdata),
        .extOsc         (extOsc),
        .timerIntEnable (timerIntEnable),
        .timerIrq       (timerIrq)
    );

    initial clk_sys = 1'b0;
    always #4 clk_sys = ~clk_sys;

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfrWrite <= 1'b1;
        sfrAddr  <= a;
        sfrWdata <= d;
        @(posedge clk_sys);
        sfrWrite <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        sfrRead <= 1'b1;
        sfrAddr <= a;
        @(posedge clk_sys);
        sfrRead <= 1'b0;
        #1;
        d = sfrRdata;
    endtask : rd

    // bounded wait for the interrupt line
    task automatic wait_irq();
        int n;
        n = 0;
        while (timerIrq !== 1'b1 && n < 2000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 2000) begin
            n_mismatch++;
            $display("mismatch irq wait expected 1 seen timeout");
            give_verdict();
        end
    endtask : wait_irq

    task automatic test_reset_values();
        rd(timer3_pkg::ADDR_RELOAD_LOW, rv);  `CHK("reload low rst", 8'h00, rv)
        rd(timer3_pkg::ADDR_RELOAD_HIGH, rv); `CHK("reload high rst", 8'h00, rv)
        rd(timer3_pkg::ADDR_COUNT_LOW, rv);   `CHK("count low rst", 8'h00, rv)
        rd(timer3_pkg::ADDR_CONTROL, rv);     `CHK("control rst", 8'h00, rv)
        rd(8'h90, rv);                        `CHK("unmapped", 8'h00, rv)
    endtask : test_reset_values

    task automatic test_register_access();
        wr(timer3_pkg::ADDR_RELOAD_LOW, 8'hA5);
        wr(timer3_pkg::ADDR_RELOAD_HIGH, 8'h5A);
        rd(timer3_pkg::ADDR_RELOAD_LOW, rv);  `CHK("reload low rw", 8'hA5, rv)
        rd(timer3_pkg::ADDR_RELOAD_HIGH, rv); `CHK("reload high rw", 8'h5A, rv)
        wr(timer3_pkg::ADDR_CONTROL, 8'h23);
        rd(timer3_pkg::ADDR_CONTROL, rv);     `CHK("control bit1", 8'h21, rv)
        wr(timer3_pkg::ADDR_CONTROL, 8'h00);
    endtask : test_register_access

    task automatic test_wide_wrap();
        wr(timer3_pkg::ADDR_CLOCK_CONTROL, 8'h10);
        wr(timer3_pkg::ADDR_RELOAD_LOW, 8'h34);
        wr(timer3_pkg::ADDR_RELOAD_HIGH, 8'h12);
        wr(timer3_pkg::ADDR_COUNT_LOW, 8'h40);
        repeat (20) @(posedge clk_sys);
        rd(timer3_pkg::ADDR_COUNT_LOW, rv);   `CHK("held while stopped", 8'h40, rv)
        wr(timer3_pkg::ADDR_COUNT_HIGH, 8'hFF);
        wr(timer3_pkg::ADDR_COUNT_LOW, 8'hFE);
        timerIntEnable <= 1'b1;
        wr(timer3_pkg::ADDR_CONTROL, 8'h04);
        wait_irq();
        repeat (20) @(posedge clk_sys);
        rd(timer3_pkg::ADDR_COUNT_HIGH, rv);  `CHK("reload high byte", 8'h12, rv)
        rd(timer3_pkg::ADDR_CONTROL, rv);     `CHK("flags after wrap", 8'hC4, rv)
        wr(timer3_pkg::ADDR_CONTROL, 8'h00);
        repeat (2) @(posedge clk_sys);
        `CHK("irq after clear", 1'b0, timerIrq)
    endtask : test_wide_wrap

    task automatic test_split_low();
        wr(timer3_pkg::ADDR_CLOCK_CONTROL, 8'h30);
        wr(timer3_pkg::ADDR_RELOAD_LOW, 8'h80);
        wr(timer3_pkg::ADDR_RELOAD_HIGH, 8'h90);
        wr(timer3_pkg::ADDR_COUNT_HIGH, 8'hF0);
        wr(timer3_pkg::ADDR_COUNT_LOW, 8'hF0);
        wr(timer3_pkg::ADDR_CONTROL, 8'h08);
        repeat (30) @(posedge clk_sys);
        rd(timer3_pkg::ADDR_COUNT_HIGH, rv);  `CHK("high gated", 8'hF0, rv)
        rd(timer3_pkg::ADDR_COUNT_LOW, rv);   `CHK("low reloaded", 1'b1, rv[7])
        rd(timer3_pkg::ADDR_CONTROL, rv);     `CHK("low flag only", 8'h48, rv)
        `CHK("no irq without low en", 1'b0, timerIrq)
        wr(timer3_pkg::ADDR_CONTROL, 8'h68);
        repeat (2) @(posedge clk_sys);
        `CHK("irq with low en", 1'b1, timerIrq)
        wr(timer3_pkg::ADDR_CONTROL, 8'h0C);
        repeat (20) @(posedge clk_sys);
        rd(timer3_pkg::ADDR_COUNT_HIGH, rv);  `CHK("high reloaded", 4'h9, rv[7:4])
        rd(timer3_pkg::ADDR_CONTROL, rv);     `CHK("high flag only", 8'h8C, rv)
        `CHK("irq on high wrap", 1'b1, timerIrq)
        wr(timer3_pkg::ADDR_CONTROL, 8'h00);
        timerIntEnable <= 1'b0;
    endtask : test_split_low

    task automatic test_div12();
        wr(timer3_pkg::ADDR_CLOCK_CONTROL, 8'h00);
        wr(timer3_pkg::ADDR_COUNT_HIGH, 8'h00);
        wr(timer3_pkg::ADDR_COUNT_LOW, 8'h00);
        wr(timer3_pkg::ADDR_CONTROL, 8'h04);
        repeat (240) @(posedge clk_sys);
        wr(timer3_pkg::ADDR_CONTROL, 8'h00);
        rd(timer3_pkg::ADDR_COUNT_LOW, rv);
        `CHK("div12 count", 1'b1, (rv >= 8'd19 && rv <= 8'd21))
    endtask : test_div12

    task automatic test_byte_select();
        wr(timer3_pkg::ADDR_CLOCK_CONTROL, 8'h20);
        wr(timer3_pkg::ADDR_COUNT_HIGH, 8'h00);
        wr(timer3_pkg::ADDR_COUNT_LOW, 8'h00);
        wr(timer3_pkg::ADDR_CONTROL, 8'h0C);
        repeat (24) @(posedge clk_sys);
        wr(timer3_pkg::ADDR_CONTROL, 8'h08);
        rd(timer3_pkg::ADDR_COUNT_HIGH, rv);
        `CHK("high on system_clock", 1'b1, (rv >= 8'd20 && rv <= 8'd30))
        rd(timer3_pkg::ADDR_COUNT_LOW, rv);
        `CHK("low on div12", 1'b1, (rv <= 8'd4))
        wr(timer3_pkg::ADDR_CONTROL, 8'h00);
    endtask : test_byte_select

    task automatic test_ext_clock();
        wr(timer3_pkg::ADDR_CLOCK_CONTROL, 8'h00);
        wr(timer3_pkg::ADDR_CONTROL, 8'h00);
        wr(timer3_pkg::ADDR_COUNT_HIGH, 8'h00);
        wr(timer3_pkg::ADDR_COUNT_LOW, 8'h00);
        wr(timer3_pkg::ADDR_CONTROL, 8'h0D);
        // sixteen slow oscillator periods
        for (int i = 0; i < 16; i++) begin
            repeat (5) @(posedge clk_sys);
            extOsc <= 1'b1;
            repeat (5) @(posedge clk_sys);
            extOsc <= 1'b0;
        end
        repeat (10) @(posedge clk_sys);
        rd(timer3_pkg::ADDR_COUNT_HIGH, rv);  `CHK("ext high ticks", 8'h02, rv)
        rd(timer3_pkg::ADDR_COUNT_LOW, rv);   `CHK("ext low ticks", 8'h02, rv)
    endtask : test_ext_clock

    initial begin
        n_mismatch     = 0;
        checked        = 0;
        reset          = 1'b1;
        sfrAddr        = 8'h00;
        sfrWrite       = 1'b0;
        sfrRead        = 1'b0;
        sfrWdata       = 8'h00;
        extOsc         = 1'b0;
        timerIntEnable = 1'b0;
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        test_reset_values();
        test_register_access();
        test_wide_wrap();
        test_split_low();
        test_div12();
        test_byte_select();
        test_ext_clock();
        give_verdict();
    end
endmodule : timer3_split_autoreload_tb
